// >>> rtl/blink_gen.sv
`timescale 1ns/1ps
// ********************************************************************
// Square wave for the flashing fault lamp
// ********************************************************************
module blink_gen #(
    parameter int HALF_CYC = fault_pkg::BLINK_HALF_CYC
) (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic enable,
    output logic      wave
);
    logic [31:0] cnt_q;
    always_ff @(posedge aclk) begin
        if (!aresetn || !enable) begin
            cnt_q <= 32'h0000_0000;
            wave  <= 1'b0;
        end else if (cnt_q >= 32'(HALF_CYC - 1)) begin
            cnt_q <= 32'h0000_0000;
            wave  <= ~wave;
        end else begin
            cnt_q <= cnt_q + 32'h0000_0001;
        end
    end
endmodule : blink_gen

// >>> rtl/nonfatal_fault_reporter.sv
`timescale 1ns/1ps
module nonfatal_fault_reporter #(
    parameter int ISR_LIMIT   = fault_pkg::ISR_LIMIT_CYC,
    parameter int CYCLE_LIMIT = fault_pkg::CYCLE_LIMIT_CYC,
    parameter int BLINK_HALF  = fault_pkg::BLINK_HALF_CYC,
    parameter int NUNITS      = 10
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Detection sources inside the CPU, same clock
    input  wire logic        intr_xfer_fail,
    input  wire logic        isr_active,
    input  wire logic        remote_or_link_busy,
    input  wire logic        refresh_kind_mismatch,
    input  wire logic        dense_xfer_fail,
    input  wire logic [NUNITS-1:0] dense_unit_id,
    input  wire logic        setup_read,
    input  wire logic [2:0]  setup_bad_part,
    input  wire logic        comm_board_fault,
    input  wire logic        cassette_xfer_req,
    input  wire logic        memory_read_only,
    input  wire logic        memory_short,
    input  wire logic        cassette_sum_bad,
    input  wire logic        scan_start,
    input  wire logic        io_table_mismatch,
    input  wire logic        remote_fail,
    input  wire logic        remote_master,
    input  wire logic        special_unit_fail,
    input  wire logic [3:0]  special_unit_num,
    // Battery detector is an analog pin
    input  wire logic        battery_weak_pin,
    // Status outputs
    output logic [7:0]       fault_code,
    output logic             fault_lamp,
    output logic             power_lamp,
    output logic             run_lamp,
    output logic             program_run,
    output logic [15:0]      restart_bits
);
    logic [31:0] ctrl_q;
    logic [fault_pkg::NSRC-1:0] pend_q;
    logic [fault_pkg::NSRC-1:0] ev;
    logic        batt_s1_q, batt_s2_q, batt_pend_q;
    logic [7:0]  user_q, code_q;
    logic        user_pend_q;
    logic [2:0]  setup_part_q;
    logic        setup_seen_q;
    logic [NUNITS-1:0] dense_q;
    logic        remote_master_q;
    logic [3:0]  unit_q;
    logic [31:0] isr_cnt_q, cyc_cnt_q;
    logic        isr_flag_q;
    logic        user_stb, clear_stb, clear_ok, any_pend, blink;

    function automatic logic [7:0] code_of(input int idx);
        case (idx)
            fault_pkg::SRC_8A: code_of = fault_pkg::CODE_8A;
            fault_pkg::SRC_8B: code_of = fault_pkg::CODE_8B;
            fault_pkg::SRC_9A: code_of = fault_pkg::CODE_9A;
            fault_pkg::SRC_9B: code_of = fault_pkg::CODE_9B;
            fault_pkg::SRC_9C: code_of = fault_pkg::CODE_9C;
            fault_pkg::SRC_9D: code_of = fault_pkg::CODE_9D;
            fault_pkg::SRC_F8: code_of = fault_pkg::CODE_F8;
            fault_pkg::SRC_E7: code_of = fault_pkg::CODE_E7;
            fault_pkg::SRC_B0: code_of = fault_pkg::CODE_B0;
            fault_pkg::SRC_B1: code_of = fault_pkg::CODE_B1;
            fault_pkg::SRC_D0: code_of = fault_pkg::CODE_D0;
            default:           code_of = fault_pkg::CODE_NONE;
        endcase
    endfunction : code_of

    function automatic logic bcd_ok(input logic [7:0] v);
        bcd_ok = (v[7:4] <= 4'h9) && (v[3:0] <= 4'h9) && (v != 8'h00);
    endfunction : bcd_ok

    // ****************************************************************
    // AXI4-Lite slave: single beat, answers one cycle after both taken
    // ****************************************************************
    logic        aw_held_q, w_held_q;
    logic [7:0]  aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;
    logic        wr_fire;
    assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_fire       = aw_held_q && w_held_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q  <= 32'h0000_0000;
            w_strb_q  <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held_q    <= 1'b0;
                w_held_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_addr_q == fault_pkg::ADDR_CTRL ||
                                 aw_addr_q == fault_pkg::ADDR_RESTART) ? 2'h0 : 2'h2;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Control word; clear and user strobe bits self-clear
    logic ctrl_wr, rst_wr;
    assign ctrl_wr   = wr_fire && aw_addr_q == fault_pkg::ADDR_CTRL;
    assign rst_wr    = wr_fire && aw_addr_q == fault_pkg::ADDR_RESTART;
    assign user_stb  = ctrl_wr && w_strb_q[0] && w_data_q[fault_pkg::CTRL_USER_BIT];
    assign clear_stb = ctrl_wr && w_strb_q[0] && w_data_q[fault_pkg::CTRL_CLEAR_BIT];
    assign clear_ok  = clear_stb && ctrl_q[1:0] == fault_pkg::MODE_PROGRAM;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= fault_pkg::RESET_ZERO;
        end else if (ctrl_wr) begin
            for (int b = 0; b < 4; b++) begin
                if (w_strb_q[b]) ctrl_q[b*8 +: 8] <= w_data_q[b*8 +: 8];
            end
            ctrl_q[fault_pkg::CTRL_CLEAR_BIT] <= 1'b0;
            ctrl_q[fault_pkg::CTRL_USER_BIT]  <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            restart_bits <= 16'h0000;
        end else if (rst_wr) begin
            restart_bits <= restart_bits ^ w_data_q[15:0];
        end
    end

    // ****************************************************************
    // Detection
    // ****************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn || !isr_active) begin
            isr_cnt_q  <= 32'h0000_0000;
            isr_flag_q <= 1'b0;
        end else begin
            if (remote_or_link_busy && isr_cnt_q < 32'(ISR_LIMIT)) begin
                isr_cnt_q <= isr_cnt_q + 32'h0000_0001;
            end
            if (isr_cnt_q == 32'(ISR_LIMIT - 1) && remote_or_link_busy) begin
                isr_flag_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || scan_start) begin
            cyc_cnt_q <= 32'h0000_0000;
        end else if (cyc_cnt_q <= 32'(CYCLE_LIMIT)) begin
            cyc_cnt_q <= cyc_cnt_q + 32'h0000_0001;
        end
    end

    always_comb begin
        ev = '0;
        ev[fault_pkg::SRC_8A] = intr_xfer_fail;
        ev[fault_pkg::SRC_8B] = (isr_cnt_q == 32'(ISR_LIMIT - 1) && remote_or_link_busy
                                 && isr_active && !isr_flag_q)
                                || refresh_kind_mismatch;
        ev[fault_pkg::SRC_9A] = dense_xfer_fail;
        ev[fault_pkg::SRC_9B] = setup_read && !setup_seen_q
                                && setup_bad_part != 3'h0;
        ev[fault_pkg::SRC_9C] = comm_board_fault;
        ev[fault_pkg::SRC_9D] = cassette_xfer_req &&
                                (ctrl_q[1:0] != fault_pkg::MODE_PROGRAM ||
                                 memory_read_only || memory_short ||
                                 cassette_sum_bad);
        ev[fault_pkg::SRC_F8] = cyc_cnt_q == 32'(CYCLE_LIMIT);
        ev[fault_pkg::SRC_E7] = io_table_mismatch;
        ev[fault_pkg::SRC_B0] = remote_fail && !remote_master;
        ev[fault_pkg::SRC_B1] = remote_fail && remote_master;
        ev[fault_pkg::SRC_D0] = special_unit_fail;
    end

    // Detail words; first setup read only, per the first use
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            setup_seen_q    <= 1'b0;
            setup_part_q    <= 3'h0;
            dense_q         <= '0;
            remote_master_q <= 1'b0;
            unit_q          <= 4'h0;
        end else begin
            if (setup_read) begin
                setup_seen_q <= 1'b1;
            end
            if (ev[fault_pkg::SRC_9B]) begin
                setup_part_q <= setup_bad_part;
            end
            if (dense_xfer_fail) begin
                dense_q <= dense_q | dense_unit_id;
            end
            if (remote_fail) begin
                remote_master_q <= remote_master;
            end
            if (special_unit_fail) begin
                unit_q <= special_unit_num;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            batt_s1_q <= 1'b0;
            batt_s2_q <= 1'b0;
        end else begin
            batt_s1_q <= battery_weak_pin;
            batt_s2_q <= batt_s1_q;
        end
    end

    // ****************************************************************
    // Pending set and current code; a new event beats a clear
    // ****************************************************************
    logic [7:0] next_code;
    logic [fault_pkg::NSRC-1:0] pend_next;
    always_comb begin
        pend_next = pend_q | ev;
        next_code = fault_pkg::CODE_NONE;
        if (batt_pend_q || batt_s2_q) begin
            next_code = fault_pkg::CODE_F7;
        end
        for (int i = fault_pkg::NSRC - 1; i >= 0; i--) begin
            if (pend_next[i]) next_code = code_of(i);
        end
        if (user_pend_q) begin
            next_code = user_q;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pend_q      <= '0;
            batt_pend_q <= 1'b0;
            user_pend_q <= 1'b0;
            user_q      <= 8'h00;
        end else begin
            pend_q      <= pend_q | ev;
            batt_pend_q <= batt_pend_q | batt_s2_q;
            if (user_stb && bcd_ok(ctrl_q[15:8])) begin
                user_pend_q <= 1'b1;
                user_q      <= ctrl_q[15:8];
            end else if (user_stb && ctrl_q[15:8] == 8'h00) begin
                // Drop only the shown code, the rest move up
                if (user_pend_q) begin
                    user_pend_q <= 1'b0;
                end else begin
                    for (int i = 0; i < fault_pkg::NSRC; i++) begin
                        if (code_of(i) == code_q && !ev[i]) pend_q[i] <= 1'b0;
                    end
                    if (code_q == fault_pkg::CODE_F7 && !batt_s2_q) batt_pend_q <= 1'b0;
                end
            end else if (clear_ok) begin
                user_pend_q <= 1'b0;
                pend_q      <= ev;
                batt_pend_q <= batt_s2_q;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            code_q <= fault_pkg::CODE_NONE;
        end else begin
            code_q <= next_code;
        end
    end

    assign any_pend   = code_q != fault_pkg::CODE_NONE;
    assign fault_code = code_q;

    blink_gen #(
        .HALF_CYC (BLINK_HALF)
    ) u_blink (
        .aclk    (aclk),
        .aresetn (aresetn),
        .enable  (any_pend),
        .wave    (blink)
    );

    // Lamps: nonfatal faults never stop the scan
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fault_lamp  <= 1'b0;
            power_lamp  <= 1'b0;
            run_lamp    <= 1'b0;
            program_run <= 1'b0;
        end else begin
            power_lamp  <= 1'b1;
            run_lamp    <= ctrl_q[1:0] != fault_pkg::MODE_PROGRAM;
            program_run <= ctrl_q[1:0] != fault_pkg::MODE_PROGRAM;
            fault_lamp  <= any_pend && !blink;
        end
    end

    // ****************************************************************
    // Read path
    // ****************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= 2'h0;
            case (s_axi_araddr)
                fault_pkg::ADDR_CTRL:    s_axi_rdata <= ctrl_q;
                fault_pkg::ADDR_EVENT:   s_axi_rdata <= 32'(pend_q);
                fault_pkg::ADDR_CODE:    s_axi_rdata <= {24'h000000, code_q};
                fault_pkg::ADDR_PENDING: s_axi_rdata <= {user_pend_q, batt_pend_q,
                                                         19'h00000, pend_q};
                fault_pkg::ADDR_DETAIL:  s_axi_rdata <= {remote_master_q, 28'h0000000,
                                                         setup_part_q};
                fault_pkg::ADDR_UNIT:    s_axi_rdata <= {12'h000, 16'(dense_q), unit_q};
                fault_pkg::ADDR_LAMPS:   s_axi_rdata <= {29'h00000000, fault_lamp,
                                                         run_lamp, power_lamp};
                fault_pkg::ADDR_RESTART: s_axi_rdata <= {16'h0000, restart_bits};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= 2'h2;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_wdog_code: assert property (@(posedge aclk) disable iff (!aresetn)
        ev[fault_pkg::SRC_F8] |=> pend_q[fault_pkg::SRC_F8])
        else $error("watchdog overrun not recorded");
    a_remote_sel: assert property (@(posedge aclk) disable iff (!aresetn)
        remote_fail && remote_master |=> pend_q[fault_pkg::SRC_B1])
        else $error("remote master 1 fault not recorded");
    a_clear_mode: assert property (@(posedge aclk) disable iff (!aresetn)
        clear_stb && ctrl_q[1:0] != fault_pkg::MODE_PROGRAM && !user_stb
        |=> pend_q == ($past(pend_q) | $past(ev)))
        else $error("clear honoured outside program mode");
    a_lamp_off: assert property (@(posedge aclk) disable iff (!aresetn)
        code_q == fault_pkg::CODE_NONE |=> !fault_lamp)
        else $error("fault lamp lit with no code");
    a_run_on: assert property (@(posedge aclk) disable iff (!aresetn)
        any_pend && ctrl_q[1:0] == fault_pkg::MODE_RUN ##1 ctrl_q[1:0] == fault_pkg::MODE_RUN
        |-> run_lamp && program_run)
        else $error("run dropped on nonfatal fault");
    a_code_shown: assert property (@(posedge aclk) disable iff (!aresetn)
        pend_q[fault_pkg::SRC_8A] && !user_pend_q |-> ##1 code_q == fault_pkg::CODE_8A)
        else $error("8A not shown first");
    a_user_code: assert property (@(posedge aclk) disable iff (!aresetn)
        user_stb && bcd_ok(ctrl_q[15:8]) |=> ##1 code_q == $past(ctrl_q[15:8], 2))
        else $error("user fault code not shown");
    a_setup_bits: assert property (@(posedge aclk) disable iff (!aresetn)
        ev[fault_pkg::SRC_9B] |=> setup_part_q == $past(setup_bad_part))
        else $error("setup part bits wrong");
    a_battery: assert property (@(posedge aclk) disable iff (!aresetn)
        batt_s2_q |=> batt_pend_q)
        else $error("battery fault lost");
    c_user_fault: cover property (@(posedge aclk) disable iff (!aresetn) user_stb);
    c_multi: cover property (@(posedge aclk) disable iff (!aresetn)
        pend_q[fault_pkg::SRC_9C] && pend_q[fault_pkg::SRC_E7]);
    c_clear: cover property (@(posedge aclk) disable iff (!aresetn) clear_ok);
endmodule : nonfatal_fault_reporter

// >>> shared/fault_pkg.sv
package fault_pkg;
    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_EVENT    = 8'h04;
    localparam logic [7:0] ADDR_CODE     = 8'h08;
    localparam logic [7:0] ADDR_PENDING  = 8'h0c;
    localparam logic [7:0] ADDR_DETAIL   = 8'h10;
    localparam logic [7:0] ADDR_UNIT     = 8'h14;
    localparam logic [7:0] ADDR_LAMPS    = 8'h18;
    localparam logic [7:0] ADDR_RESTART  = 8'h1c;
    // CTRL fields
    localparam int CTRL_MODE_LSB   = 0;  // 2 bits
    localparam int CTRL_CLEAR_BIT  = 2;
    localparam int CTRL_USER_BIT   = 3;
    localparam int CTRL_UNUM_LSB   = 8;  // 8 bits BCD
    localparam logic [1:0] MODE_PROGRAM = 2'h0;
    localparam logic [1:0] MODE_MONITOR = 2'h1;
    localparam logic [1:0] MODE_RUN     = 2'h2;
    // ****************************************************************
    // Fault sources, lowest index served first
    // ****************************************************************
    localparam int NSRC = 11;
    localparam int SRC_8A = 0;
    localparam int SRC_8B = 1;
    localparam int SRC_9A = 2;
    localparam int SRC_9B = 3;
    localparam int SRC_9C = 4;
    localparam int SRC_9D = 5;
    localparam int SRC_F8 = 6;
    localparam int SRC_E7 = 7;
    localparam int SRC_B0 = 8;
    localparam int SRC_B1 = 9;
    localparam int SRC_D0 = 10;
    localparam int SRC_F7_NOTE = 11; // battery is a level input, see below
    localparam logic [7:0] CODE_NONE = 8'h00;
    localparam logic [7:0] CODE_8A = 8'h8a;
    localparam logic [7:0] CODE_8B = 8'h8b;
    localparam logic [7:0] CODE_9A = 8'h9a;
    localparam logic [7:0] CODE_9B = 8'h9b;
    localparam logic [7:0] CODE_9C = 8'h9c;
    localparam logic [7:0] CODE_9D = 8'h9d;
    localparam logic [7:0] CODE_F8 = 8'hf8;
    localparam logic [7:0] CODE_E7 = 8'he7;
    localparam logic [7:0] CODE_B0 = 8'hb0;
    localparam logic [7:0] CODE_B1 = 8'hb1;
    localparam logic [7:0] CODE_D0 = 8'hd0;
    localparam logic [7:0] CODE_F7 = 8'hf7;
    // ****************************************************************
    // Timing at 100 MHz
    // ****************************************************************
    localparam int CLK_MHZ          = 100;
    localparam int ISR_LIMIT_MS     = 10;
    localparam int CYCLE_LIMIT_MS   = 100;
    localparam int ISR_LIMIT_CYC    = ISR_LIMIT_MS * 1000 * CLK_MHZ;
    localparam int CYCLE_LIMIT_CYC  = CYCLE_LIMIT_MS * 1000 * CLK_MHZ;
    localparam int BLINK_HALF_MS    = 250;
    localparam int BLINK_HALF_CYC   = BLINK_HALF_MS * 1000 * CLK_MHZ;
    localparam logic [31:0] RESET_ZERO = 32'h0000_0000;
endpackage : fault_pkg

// >>> sim/nonfatal_fault_reporter_bench.sv
`timescale 1ns/1ps
module nonfatal_fault_reporter_bench;
    logic        aclk, aresetn, awv, wv, bready, arv, rready, batt, scan_start;
    logic        awr, wr, bv, arr, rv, f_lamp, p_lamp, r_lamp, pr, isr, busy;
    logic [7:0]  awaddr, araddr, fault_code, period, ucode, q[$];
    logic [31:0] wdata, rdata;
    logic [1:0]  rresp, bresp;
    logic [15:0] restart_bits, rs;
    logic [10:0] ev;
    logic [9:0]  dense_id;
    logic [3:0]  unum4;
    logic [2:0]  part;
    logic [4:0]  n;
    int          n_fail, total_checks, seed, k, t;
    logic [7:0]  codes [11] = '{8'h8a, 8'h8b, 8'h9a, 8'h9b, 8'h9c, 8'h9d, 8'hf8, 8'he7,
                                8'hb0, 8'hb1, 8'hd0};
    nonfatal_fault_reporter #(.ISR_LIMIT(20), .CYCLE_LIMIT(50), .BLINK_HALF(4)) DUT (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
        .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rready),
        .intr_xfer_fail(ev[0]), .isr_active(isr), .remote_or_link_busy(busy),
        .refresh_kind_mismatch(ev[1]), .dense_xfer_fail(ev[2]), .dense_unit_id(dense_id),
        .setup_read(ev[3]), .setup_bad_part(part), .comm_board_fault(ev[4]),
        .cassette_xfer_req(ev[5]), .memory_read_only(ev[5]), .memory_short(1'b0),
        .cassette_sum_bad(1'b0), .scan_start(scan_start), .io_table_mismatch(ev[7]),
        .remote_fail(ev[8] | ev[9]), .remote_master(ev[9]), .special_unit_fail(ev[10]),
        .special_unit_num(unum4), .battery_weak_pin(batt), .fault_code(fault_code),
        .fault_lamp(f_lamp), .power_lamp(p_lamp), .run_lamp(r_lamp), .program_run(pr),
        .restart_bits(restart_bits));
    scan_engine_model u_scan (.aclk(aclk), .aresetn(aresetn), .period(period),
        .scan_start(scan_start));
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    task give_verdict();
        $display("checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : give_verdict
    task chk(input logic [33:0] got, input logic [33:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
        // A wait that ran out is a failure even if stale data happens to match
        if (t >= 50) begin
            n_fail++;
            give_verdict();
        end
    endtask : chk
    task wr_reg(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
        @(posedge aclk);
        {awaddr, wdata, awv, wv, bready} <= {a, d, 3'h7};
        for (t = 0; t < 50; t++) begin
            @(posedge aclk);
            if (awr) awv <= 1'b0;
            if (wr) wv <= 1'b0;
            if (bv) break;
        end
        bready <= 1'b0;
        chk({bv, bresp}, {1'b1, er});
    endtask : wr_reg
    // Fault code is compared both in the register and on the pins
    task rd_chk(input logic [31:0] e, input logic [7:0] a = 8'h08, input logic [1:0] er = 2'h0);
        @(posedge aclk);
        {araddr, arv, rready} <= {a, 2'h3};
        for (t = 0; t < 50; t++) begin
            @(posedge aclk);
            if (arr) arv <= 1'b0;
            if (rv) break;
        end
        rready <= 1'b0;
        chk({rresp, rdata}, {er, e});
        if (a == 8'h08) chk(fault_code, e[7:0]);
    endtask : rd_chk
    task pulse(input int s);
        ev <= 11'h1 << s;
        @(posedge aclk);
        ev <= '0;
    endtask : pulse
    task lamp_cnt(input logic [4:0] e);
        n = 5'h00;
        // The lamp register trails the clear by two edges, one after the code
        repeat (2) @(posedge aclk);
        repeat (16) begin
            @(posedge aclk);
            n += 5'(f_lamp);
        end
        chk(n, e);
    endtask : lamp_cnt
    initial begin
        seed = 32'h4ca7;
        {aresetn, awv, wv, bready, arv, rready, batt, isr, busy, ev, awaddr, araddr, wdata} <= '0;
        {period, dense_id} <= {8'h14, 10'($random(seed))};
        {part, unum4} <= {3'($random(seed)) | 3'h1, 4'($random(seed))};
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        rd_chk(32'h0);
        rd_chk(32'h0, 8'h20, 2'h2);
        wr_reg(8'h08, 32'hff, 2'h2);
        chk({p_lamp, r_lamp, pr}, 3'h4);
        for (k = 0; k < 11; k++) begin
            if (k != 6) begin
                pulse(k);
                rd_chk(codes[k]);
                wr_reg(8'h00, 32'h4);
                rd_chk(32'h0);
            end
        end
        rd_chk({1'b1, 28'h0, part}, 8'h10);
        rd_chk({12'h0, 6'h0, dense_id, unum4}, 8'h14);
        period <= 8'hc8;
        repeat (80) @(posedge aclk);
        period <= 8'h14;
        rd_chk(32'hf8);
        lamp_cnt(5'h08);
        wr_reg(8'h00, 32'h4);
        lamp_cnt(5'h00);
        k = {$random(seed)} % 99 + 1;
        ucode = 8'((k / 10) * 16 + k % 10);
        q.push_back(ucode);
        wr_reg(8'h00, {16'h0, ucode, 8'h02});
        wr_reg(8'h00, {16'h0, ucode, 8'h0a});
        chk({p_lamp, r_lamp, pr}, 3'h7);
        pulse(0);
        q.push_back(8'h8a);
        rd_chk(q[0]);
        wr_reg(8'h00, 32'h02);
        wr_reg(8'h00, 32'h0a);
        void'(q.pop_front());
        rd_chk(q[0]);
        wr_reg(8'h00, 32'h06);
        rd_chk(q[0]);
        // Clear is judged by the mode held before the write, so leave run mode first
        wr_reg(8'h00, 32'h00);
        wr_reg(8'h00, 32'h04);
        rd_chk(32'h0);
        batt <= 1'b1;
        repeat (4) @(posedge aclk);
        rd_chk(32'hf7);
        batt <= 1'b0;
        repeat (4) @(posedge aclk);
        {isr, busy} <= 2'h3;
        repeat (25) @(posedge aclk);
        {isr, busy} <= 2'h0;
        rd_chk(32'h8b);
        wr_reg(8'h00, 32'h04);
        rd_chk(32'h0);
        rs = 16'($random(seed));
        wr_reg(8'h1c, {16'h0, rs});
        chk(restart_bits, rs);
        give_verdict();
    end
endmodule : nonfatal_fault_reporter_bench

// >>> sim/scan_engine_model.sv
`timescale 1ns/1ps
// ********************
// Scan engine model
// ********************
module scan_engine_model (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic [7:0] period,
    output logic            scan_start
);
    logic [7:0] cnt_q;
    // A period above the watchdog limit stands for a slow user program
    always_ff @(posedge aclk) begin
        if (!aresetn || cnt_q >= period) begin
            cnt_q <= 8'h00;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
    assign scan_start = aresetn && cnt_q == period;
endmodule : scan_engine_model
